// >>> common/pslv_pkg.sv
// constants, register map and phase encoding of the parallel slave port
// assumes a single 50 MHz clock and an APB master with 12-bit byte addresses
package pslv_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_PORT_D_LATCH     = 10'h008;
  localparam logic [9:0] IDX_PORT_E_LATCH     = 10'h009;
  localparam logic [9:0] IDX_IRQ_FLAGS        = 10'h00C;
  localparam logic [9:0] IDX_PORT_D_DIRECTION = 10'h088;
  localparam logic [9:0] IDX_CTRL_STATUS      = 10'h089;
  localparam logic [9:0] IDX_IRQ_ENABLES      = 10'h08C;
  localparam logic [9:0] IDX_ANALOG_CFG       = 10'h09F;
  localparam logic [9:0] IDX_BIT_OP           = 10'h0A0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_INPUT_FULL  = 7;
  localparam int CTRL_OUTPUT_FULL = 6;
  localparam int CTRL_OVERFLOW    = 5;
  localparam int CTRL_MODE_SEL    = 4;
  localparam int IRQ_SLAVE_PORT   = 7;
  localparam int BIT_OP_SET       = 8;
  localparam int BIT_OP_PORT_E    = 9;
  localparam int STRB_RD          = 0;
  localparam int STRB_WR          = 1;
  localparam int STRB_CS          = 2;

  // ----------------------------------------------------------------
  // reset values and decode constants
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_E_DIRECTION  = 3'h7;
  localparam logic [7:0] RST_D_DIRECTION  = 8'hFF;
  localparam logic [7:0] RST_IRQ_FLAGS    = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES  = 8'h00;
  localparam logic [2:0] RST_ANALOG_CFG   = 3'h0;
  localparam logic [2:0] PCFG_ALL_DIGITAL = 3'h7;

  // ----------------------------------------------------------------
  // instruction-cycle phases
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } pslv_phase_type;

endpackage

// >>> verilog/pslv_top.sv
// parallel slave port on port D with strobes on port E, APB registers
// assumes rd/wr/cs and data pins are asynchronous; the pad ring resolves
// pin levels from the *_oe outputs
//
// Contract
// - mode-select bit 4 of control register turns port D into slave port
// - port E pin 0 read, pin 1 write, pin 2 chip select, all low-active
// - two latches at one address: writes go out, reads return captured byte
// - in slave mode the port D direction register is ignored
// - chip select and write low start a write; data pins are captured
// - write end sets input-full and irq flag at Q4 after next Q2
// - in slave mode input-full clears only on firmware read of port D
// - another write while input-full sets the overflow flag
// - chip select and read low start a read; output-full clears at once
// - read end sets irq flag at Q4 after next Q2
// - output-full stays clear until firmware writes port D
// - outside slave mode full flags held clear; overflow kept
// - irq flag sticky until firmware clears; enable bit masks request
// - outside slave mode reads return pins, writes update the latch
// - bit operations read pins, modify, store result into output latch
// - latch written at end of instruction cycle, pins sampled at start
// - chip select low selects; strobes only count while selected
module pslv_top
  import pslv_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  port_d_in,
  output logic      [7:0]  port_d_out,
  output logic      [7:0]  port_d_oe,
  input  wire logic [2:0]  port_e_in,
  output logic      [2:0]  port_e_out,
  output logic      [2:0]  port_e_oe,
  output logic             slave_port_irq_req
);

  // ----------------------------------------------------------------
  // instruction-cycle phase generator
  // ----------------------------------------------------------------
  pslv_phase_type ph_q;
  pslv_phase_type ph_d;

  always_comb begin
    case (ph_q)
      PH_Q1:   ph_d = PH_Q2;
      PH_Q2:   ph_d = PH_Q3;
      PH_Q3:   ph_d = PH_Q4;
      PH_Q4:   ph_d = PH_Q1;
      default: ph_d = PH_Q1;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_q <= PH_Q1;
    end else if (ce) begin
      ph_q <= ph_d;
    end
  end

  wire at_q1 = (ph_q == PH_Q1);
  wire at_q2 = (ph_q == PH_Q2);
  wire at_q3 = (ph_q == PH_Q3);
  wire at_q4 = (ph_q == PH_Q4);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] strb_s1_q;
  logic [2:0] strb_s2_q;
  logic [7:0] pd_s1_q;
  logic [7:0] pd_s2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strb_s1_q <= 3'h7;
      strb_s2_q <= 3'h7;
      pd_s1_q   <= 8'h00;
      pd_s2_q   <= 8'h00;
    end else if (ce) begin
      strb_s1_q <= port_e_in;
      strb_s2_q <= strb_s1_q;
      pd_s1_q   <= port_d_in;
      pd_s2_q   <= pd_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic       mode_q;
  logic [2:0] e_dir_q;
  logic [7:0] d_dir_q;
  logic [2:0] pcfg_q;
  logic [7:0] irq_en_q;
  logic [7:0] irq_flags_q;
  logic [7:0] port_d_latch_q;
  logic [2:0] port_e_latch_q;
  logic [7:0] in_latch_q;
  logic [7:0] snap_d_q;
  logic [2:0] snap_e_q;
  logic       ibf_q;
  logic       obf_q;
  logic       input_overflow_flag_q;

  // strobes only act once the pins are configured as digital
  wire strobes_digital = (pcfg_q == PCFG_ALL_DIGITAL);
  wire slv_en = mode_q & strobes_digital;
  wire cs_act = slv_en & ~strb_s2_q[STRB_CS];
  wire wr_act = cs_act & ~strb_s2_q[STRB_WR];
  wire rd_act = cs_act & ~strb_s2_q[STRB_RD];

  // ----------------------------------------------------------------
  // external cycle tracking
  // ----------------------------------------------------------------
  logic wr_active_q;
  logic wr_pend_q;
  logic wr_arm_q;
  logic rd_active_q;
  logic rd_pend_q;
  logic rd_arm_q;

  wire wr_end   = wr_active_q & ~wr_act;
  wire rd_start = rd_act & ~rd_active_q;
  wire rd_end   = rd_active_q & ~rd_act;
  wire wr_done  = wr_arm_q & at_q4;
  wire rd_done  = rd_arm_q & at_q4;

  // completion waits for a full Q2 then the Q4 that follows it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_active_q <= 1'b0;
      wr_pend_q   <= 1'b0;
      wr_arm_q    <= 1'b0;
      rd_active_q <= 1'b0;
      rd_pend_q   <= 1'b0;
      rd_arm_q    <= 1'b0;
    end else if (ce) begin
      wr_active_q <= wr_act;
      rd_active_q <= rd_act;
      wr_pend_q   <= slv_en & (wr_end | (wr_pend_q & ~at_q2));
      wr_arm_q    <= slv_en & ((wr_pend_q & at_q2) | (wr_arm_q & ~at_q4));
      rd_pend_q   <= slv_en & (rd_end | (rd_pend_q & ~at_q2));
      rd_arm_q    <= slv_en & ((rd_pend_q & at_q2) | (rd_arm_q & ~at_q4));
    end
  end

  // ----------------------------------------------------------------
  // APB decode; accesses complete in Q4 so latches move at cycle end
  // ----------------------------------------------------------------
  logic       pready_q;
  logic       pslverr_q;
  logic [31:0] prdata_q;

  wire [9:0] idx     = paddr[11:2];
  wire       acc     = psel & penable & pready_q;
  wire       wr_acc  = acc & pwrite;
  wire       rd_acc  = acc & ~pwrite;
  wire       hit_pd  = (idx == IDX_PORT_D_LATCH);
  wire       hit_pe  = (idx == IDX_PORT_E_LATCH);
  wire       hit_irq = (idx == IDX_IRQ_FLAGS);
  wire       hit_dd  = (idx == IDX_PORT_D_DIRECTION);
  wire       hit_cs  = (idx == IDX_CTRL_STATUS);
  wire       hit_ien = (idx == IDX_IRQ_ENABLES);
  wire       hit_an  = (idx == IDX_ANALOG_CFG);
  wire       hit_bop = (idx == IDX_BIT_OP);
  wire       mapped  = hit_pd | hit_pe | hit_irq | hit_dd | hit_cs |
                       hit_ien | hit_an | hit_bop;
  wire       fw_wr_pd = wr_acc & hit_pd;
  wire       fw_rd_pd = rd_acc & hit_pd;

  // bit set or clear starts from the pin levels, not the latch
  wire       bop_wr   = wr_acc & hit_bop;
  wire       bop_on_e = pwdata[BIT_OP_PORT_E];
  wire [7:0] bop_src  = bop_on_e ? {5'h00, snap_e_q} : snap_d_q;
  wire [7:0] bop_res  = pwdata[BIT_OP_SET] ? (bop_src | pwdata[7:0])
                                           : (bop_src & ~pwdata[7:0]);

  wire [7:0] ctrl_rd = {ibf_q, obf_q, input_overflow_flag_q, mode_q, 1'b0, e_dir_q};
  wire [7:0] pd_rd   = mode_q ? in_latch_q : snap_d_q;
  wire [7:0] rd_mux  =
    hit_pd  ? pd_rd :
    hit_pe  ? {5'h00, snap_e_q} :
    hit_irq ? irq_flags_q :
    hit_dd  ? d_dir_q :
    hit_cs  ? ctrl_rd :
    hit_ien ? irq_en_q :
    hit_an  ? {5'h00, pcfg_q} : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      pready_q  <= psel & penable & ~pready_q & at_q3;
      pslverr_q <= psel & penable & ~pready_q & at_q3 & ~mapped;
      prdata_q  <= (psel & penable & ~pready_q & at_q3 & ~pwrite)
                   ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // pin snapshot at the start of the instruction cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap_d_q <= 8'h00;
      snap_e_q <= 3'h0;
    end else if (ce && at_q1) begin
      snap_d_q <= pd_s2_q;
      snap_e_q <= strb_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // data latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_d_latch_q <= 8'h00;
      port_e_latch_q <= 3'h0;
      in_latch_q     <= 8'h00;
    end else if (ce) begin
      if (fw_wr_pd) begin
        port_d_latch_q <= pwdata[7:0];
      end else if (bop_wr && !bop_on_e) begin
        port_d_latch_q <= bop_res;
      end
      if (wr_acc && hit_pe) begin
        port_e_latch_q <= pwdata[2:0];
      end else if (bop_wr && bop_on_e) begin
        port_e_latch_q <= bop_res[2:0];
      end
      if (wr_act) begin
        in_latch_q <= pd_s2_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // control, status and interrupt flags; hardware set beats clear
  // ----------------------------------------------------------------
  wire ibf_d  = ~mode_q ? 1'b0 : wr_done ? 1'b1 :
                fw_rd_pd ? 1'b0 : ibf_q;
  wire obf_d  = ~mode_q ? 1'b0 : fw_wr_pd ? 1'b1 :
                rd_start ? 1'b0 : obf_q;
  wire input_overflow_flag_d = (wr_done & ibf_q) ? 1'b1 :
                (wr_acc & hit_cs) ? pwdata[CTRL_OVERFLOW] : input_overflow_flag_q;
  wire [7:0] irq_wr = (wr_acc & hit_irq) ? pwdata[7:0] : irq_flags_q;
  wire       pif_d  = (wr_done | rd_done) ? 1'b1 :
                      irq_wr[IRQ_SLAVE_PORT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q      <= 1'b0;
      e_dir_q     <= RST_E_DIRECTION;
      d_dir_q     <= RST_D_DIRECTION;
      pcfg_q      <= RST_ANALOG_CFG;
      irq_en_q    <= RST_IRQ_ENABLES;
      irq_flags_q <= RST_IRQ_FLAGS;
      ibf_q       <= 1'b0;
      obf_q       <= 1'b0;
      input_overflow_flag_q      <= 1'b0;
    end else if (ce) begin
      ibf_q  <= ibf_d;
      obf_q  <= obf_d;
      input_overflow_flag_q <= input_overflow_flag_d;
      irq_flags_q <= {pif_d, irq_wr[6:0]};
      if (wr_acc && hit_cs) begin
        mode_q  <= pwdata[CTRL_MODE_SEL];
        e_dir_q <= pwdata[2:0];
      end
      if (wr_acc && hit_dd) begin
        d_dir_q <= pwdata[7:0];
      end
      if (wr_acc && hit_an) begin
        pcfg_q <= pwdata[2:0];
      end
      if (wr_acc && hit_ien) begin
        irq_en_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers and interrupt request
  // ----------------------------------------------------------------
  logic [7:0] pd_out_q;
  logic [7:0] pd_oe_q;
  logic [2:0] pe_out_q;
  logic [2:0] pe_oe_q;
  logic       irq_q;

  // direction register is bypassed in slave mode; data pins are driven only while an external read is active
  wire [7:0] pd_oe_d = mode_q ? {8{rd_act}} : ~d_dir_q;
  wire [2:0] pe_oe_d = mode_q ? 3'h0 : ~e_dir_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_out_q <= 8'h00;
      pd_oe_q  <= 8'h00;
      pe_out_q <= 3'h0;
      pe_oe_q  <= 3'h0;
      irq_q    <= 1'b0;
    end else if (ce) begin
      pd_out_q <= port_d_latch_q;
      pd_oe_q  <= pd_oe_d;
      pe_out_q <= port_e_latch_q;
      pe_oe_q  <= pe_oe_d;
      irq_q    <= irq_flags_q[IRQ_SLAVE_PORT] &
                  irq_en_q[IRQ_SLAVE_PORT];
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign port_d_out         = pd_out_q;
  assign port_d_oe          = pd_oe_q;
  assign port_e_out         = pe_out_q;
  assign port_e_oe          = pe_oe_q;
  assign slave_port_irq_req = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence s_wr_end;
    wr_active_q && !wr_act && slv_en;
  endsequence
  sequence s_rd_end;
    rd_active_q && !rd_act && slv_en;
  endsequence

  // exactly one Q4 falls in the window: the one after the next Q2
  wr_completion_a: assert property (s_wr_end |-> ##[3:6] (at_q4 ##1
    (!slv_en || (ibf_q && irq_flags_q[IRQ_SLAVE_PORT]))))
    else $error("write completion flags missing");
  rd_completion_a: assert property (s_rd_end |-> ##[3:6] (at_q4 ##1
    (!slv_en || irq_flags_q[IRQ_SLAVE_PORT])))
    else $error("read completion flag missing");
  flag_at_q4_a: assert property ($rose(ibf_q) |->
    $past(ph_q) == PH_Q4)
    else $error("input-full set outside Q4");
  full_clear_a: assert property (!mode_q |=> !ibf_q && !obf_q)
    else $error("full flags not held clear");
  obf_read_a: assert property (rd_start && !fw_wr_pd && mode_q |=>
    !obf_q)
    else $error("output-full not cleared on read");
  ovf_set_a: assert property (wr_done && ibf_q |=> input_overflow_flag_q)
    else $error("overflow not flagged");
  ibf_keep_a: assert property (ibf_q && mode_q && !fw_rd_pd |=>
    ibf_q)
    else $error("input-full lost without read");
  irq_mask_a: assert property (!irq_en_q[IRQ_SLAVE_PORT] |=>
    !slave_port_irq_req)
    else $error("masked irq asserted");
  bus_drive_a: assert property (mode_q |=>
    port_d_oe == {8{$past(rd_act)}})
    else $error("data pins driven out of read");
  latch_q4_a: assert property ($changed(port_d_latch_q) |->
    $past(ph_q) == PH_Q4)
    else $error("latch changed outside Q4");

endmodule

// >>> tb/pslv_ext_master.sv
// external bus master model: strobes and data bus of the slave port
// assumes the bench resolves pin levels from the slave's enables alone
module pslv_ext_master
(
  input  wire logic       clk,
  input  wire logic [7:0] pins_d,
  output logic      [2:0] strobe_n,
  output logic      [7:0] data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    strobe_n = 3'h7;
    data     = 8'h00;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // released data shows the inverse of the last byte, not a held copy
  task automatic release_bus();
    repeat (2) @(posedge clk);
    data <= ~data;
    repeat (12) @(posedge clk);
  endtask

  task automatic drive(input logic [7:0] d);
    @(posedge clk);
    data <= d;
  endtask

  // sel low keeps chip select high, so the strobe must count for nothing
  task automatic wr_byte(input logic [7:0] d, input logic sel);
    @(posedge clk);
    data     <= d;
    strobe_n <= {~sel, 2'b01};
    repeat (6) @(posedge clk);
    strobe_n <= 3'h7;
    release_bus();
  endtask

  task automatic rd_byte(output logic [7:0] q);
    @(posedge clk);
    strobe_n <= 3'h2;
    repeat (8) @(posedge clk);
    q = pins_d;
    strobe_n <= 3'h7;
    release_bus();
  endtask
endmodule

// >>> tb/parallel_slave_port_test.sv
// self-checking bench: apb register tasks plus external bus scenarios
// assumes pslv_top and the pslv_ext_master model, ce held high
`define CHK(got, exp, msg) \
  begin \
    compares = compares + 1; \
    if ((got) !== (exp)) begin \
      mismatches = mismatches + 1; \
      $display("wrong value at %0t: %s got %h expected %h", \
               $time, msg, got, exp); \
    end \
  end

module parallel_slave_port_test import pslv_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  d_out, d_oe, d_pins, m_data, xbyte;
  logic [2:0]  e_out, e_oe, e_pins, m_strobe_n;
  logic        irq_req;
  int          mismatches;
  int          compares;

  // each pin shows the dut output where the dut enables its driver, else the master's value
  assign d_pins = (d_oe & d_out) | (~d_oe & m_data);
  assign e_pins = (e_oe & e_out) | (~e_oe & m_strobe_n);

  pslv_top dut (
    .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_d_in(d_pins),
    .port_d_out(d_out), .port_d_oe(d_oe), .port_e_in(e_pins),
    .port_e_out(e_out), .port_e_oe(e_oe), .slave_port_irq_req(irq_req)
  );

  pslv_ext_master host_bus (
    .clk(clk), .pins_d(d_pins), .strobe_n(m_strobe_n), .data(m_data)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] wd, input logic [31:0] exp,
                     input logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches = mismatches + 1;
    if (!wr) `CHK(prdata, exp, "read data")
    `CHK(pslverr, err, "slave error")
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 32'h0, 1'b0);
  endtask

  task automatic rd_reg(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, exp, 1'b0);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    stop_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    compares   = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_reg(IDX_CTRL_STATUS, 32'h07);
    rd_reg(IDX_IRQ_FLAGS, 32'h00);
    rd_reg(IDX_IRQ_ENABLES, 32'h00);
    rd_reg(IDX_ANALOG_CFG, 32'h00);
    apb(1'b0, 10'h3FF, 32'h0, 32'h0, 1'b1);
    // plain port: upper nibble input, lower nibble output
    host_bus.drive(8'hC0);
    wr_reg(IDX_PORT_D_DIRECTION, 32'hF0);
    wr_reg(IDX_PORT_D_LATCH, 32'h00);
    repeat (4) @(posedge clk);
    rd_reg(IDX_PORT_D_LATCH, 32'hC0);
    `CHK(d_oe, 8'h0F, "port d enables")
    wr_reg(IDX_BIT_OP, 32'h101);
    wr_reg(IDX_BIT_OP, 32'h202);
    repeat (3) @(posedge clk);
    `CHK(d_out, 8'hC1, "set bit on port d")
    `CHK(e_out, 3'h5, "clear bit on port e")
    rd_reg(IDX_PORT_E_LATCH, 32'h07);
    wr_reg(IDX_CTRL_STATUS, 32'h00);
    repeat (3) @(posedge clk);
    `CHK(e_oe, 3'h7, "port e drivers on")
    rd_reg(IDX_PORT_E_LATCH, 32'h05);
    // slave mode, direction register set to outputs must be ignored
    wr_reg(IDX_PORT_D_DIRECTION, 32'h00);
    wr_reg(IDX_ANALOG_CFG, 32'h07);
    wr_reg(IDX_CTRL_STATUS, 32'h17);
    wr_reg(IDX_IRQ_ENABLES, 32'h80);
    repeat (3) @(posedge clk);
    `CHK(d_oe, 8'h00, "slave mode releases data")
    host_bus.wr_byte(8'h11, 1'b0);
    rd_reg(IDX_IRQ_FLAGS, 32'h00);
    host_bus.wr_byte(8'h3C, 1'b1);
    rd_reg(IDX_CTRL_STATUS, 32'h97);
    rd_reg(IDX_IRQ_FLAGS, 32'h80);
    `CHK(irq_req, 1'b1, "request raised")
    host_bus.wr_byte(8'h5A, 1'b1);
    rd_reg(IDX_CTRL_STATUS, 32'hB7);
    rd_reg(IDX_PORT_D_LATCH, 32'h5A);
    rd_reg(IDX_CTRL_STATUS, 32'h37);
    wr_reg(IDX_IRQ_ENABLES, 32'h00);
    repeat (3) @(posedge clk);
    `CHK(irq_req, 1'b0, "request masked")
    rd_reg(IDX_IRQ_FLAGS, 32'h80);
    wr_reg(IDX_IRQ_FLAGS, 32'h00);
    rd_reg(IDX_IRQ_FLAGS, 32'h00);
    wr_reg(IDX_PORT_D_LATCH, 32'h96);
    rd_reg(IDX_CTRL_STATUS, 32'h77);
    host_bus.rd_byte(xbyte);
    `CHK(xbyte, 8'h96, "external read")
    `CHK(d_oe, 8'h00, "data released after read")
    rd_reg(IDX_CTRL_STATUS, 32'h37);
    rd_reg(IDX_IRQ_FLAGS, 32'h80);
    // leaving slave mode holds full flags clear, overflow stays
    host_bus.wr_byte(8'h77, 1'b1);
    wr_reg(IDX_CTRL_STATUS, 32'h27);
    rd_reg(IDX_CTRL_STATUS, 32'h27);
    wr_reg(IDX_CTRL_STATUS, 32'h07);
    rd_reg(IDX_CTRL_STATUS, 32'h07);
    stop_test();
  end
endmodule
